// ### hdl/reload_down_counter_timer.sv
// single-channel 16-bit down-counting reload timer with register port
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "reload_timer_consts.svh"
module reload_down_counter_timer (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // register port
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // timer input pin
    input  wire logic        timer_input_pin_in,
    // general-purpose port behind the output pin
    input  wire logic        gpio_out_in,
    input  wire logic        gpio_dir_in,
    // timer output pin and interrupt
    output logic             timer_output_pin_out,
    output logic             timer_output_pin_oe_n_out,
    output logic             underflow_irq_out
);

    // mode register fields
    logic [2:0]  count_clock_select_r;
    logic [2:0]  trigger_mode_select_r;
    // control register fields
    logic        output_pin_enable_r;
    logic        output_level_select_r;
    logic        reload_select_r;
    logic        underflow_irq_enable_r;
    logic        underflow_flag_r;
    logic        count_enable_bit_r;
    logic        software_start_bit_r;
    // counter, reload and read latch
    logic [15:0] count_r;
    logic [15:0] reload_r;
    logic [7:0]  reload_hi_buf_r;
    logic [7:0]  count_lo_latch_r;
    // prescaler and pin state
    logic [6:0]  prescale_r;
    logic [7:0]  tap_tick;
    logic        ti_prev_r;
    logic        toggle_r;
    logic        timer_level_nxt;
    logic [7:0]  rdata_r;
    reload_timer_pkg::run_state_e state_r;
    reload_timer_pkg::run_state_e state_nxt;

    // decoded strobes and count qualifiers
    logic        wr_mode, wr_ctl, wr_hi, wr_lo, count_enable_bit_nxt;
    logic        event_mode, gate_mode, ext_trig_mode;
    logic        rise, fall, edge_hit, gate_on;
    logic        sw_start, start_evt, tick, count_ok;
    logic        uf_evt, dec_evt, running;

    // register address decode
    assign wr_mode = wr_in && (addr_in == `RT_ADDR_MODE);
    assign wr_ctl  = wr_in && (addr_in == `RT_ADDR_CTL);
    assign wr_hi   = wr_in && (addr_in == `RT_ADDR_HI);
    assign wr_lo   = wr_in && (addr_in == `RT_ADDR_LO);
    assign count_enable_bit_nxt = wr_ctl ? wdata_in[`RT_F_COUNT_ENABLE_BIT] : count_enable_bit_r;

    // clock and trigger mode decode
    assign event_mode    = (count_clock_select_r == `RT_CSL_EVENT);
    assign gate_mode     = !event_mode && trigger_mode_select_r[`RT_M_GATE];
    assign ext_trig_mode = !event_mode && !trigger_mode_select_r[`RT_M_GATE]
                           && (trigger_mode_select_r[`RT_M_FALL]
                               || trigger_mode_select_r[`RT_M_RISE]);

    // input pin edge and level detection
    assign rise     = timer_input_pin_in && !ti_prev_r;
    assign fall     = !timer_input_pin_in && ti_prev_r;
    assign edge_hit = (trigger_mode_select_r[`RT_M_RISE] && rise)
                      || (trigger_mode_select_r[`RT_M_FALL] && fall);
    assign gate_on  = (timer_input_pin_in == trigger_mode_select_r[`RT_M_RISE]);

    // start conditions
    assign sw_start  = wr_ctl && wdata_in[`RT_F_TRG] && count_enable_bit_nxt
                       && !gate_mode;
    assign start_evt = count_enable_bit_nxt && (state_r != reload_timer_pkg::ST_IDLE
                                    || sw_start)
                       && (sw_start
                           || (ext_trig_mode && edge_hit)
                           || (gate_mode && gate_on
                               && state_r == reload_timer_pkg::ST_WAIT));

    // count clock source
    assign tick = event_mode ? edge_hit
                : tap_tick[count_clock_select_r];

    // count qualification
    assign running  = (state_r == reload_timer_pkg::ST_RUN);
    assign count_ok = running && tick && count_enable_bit_nxt && !start_evt
                      && !(gate_mode && !gate_on);
    assign uf_evt   = count_ok && (count_r == `RT_CNT_ZERO);
    assign dec_evt  = count_ok && (count_r != `RT_CNT_ZERO);

    // prescaler taps, tap i ticks once every 2^(i+1) cycles
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_tap
            if (gi < `RT_PRE_TAPS) begin : g_used
                assign tap_tick[gi] = &prescale_r[gi:0];
            end else begin : g_event
                assign tap_tick[gi] = 1'b0;
            end
        end
    endgenerate

    // free-running prescaler
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prescale_r <= `RT_PRE_RST;
        end else begin
            prescale_r <= prescale_r + `RT_PRE_STEP;
        end
    end

    // previous input pin level
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ti_prev_r <= 1'b0;
        end else begin
            ti_prev_r <= timer_input_pin_in;
        end
    end

    // operation state sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            reload_timer_pkg::ST_IDLE: begin
                if (start_evt) begin
                    state_nxt = reload_timer_pkg::ST_RUN;
                end else if (count_enable_bit_nxt) begin
                    state_nxt = reload_timer_pkg::ST_WAIT;
                end
            end
            reload_timer_pkg::ST_WAIT: begin
                if (!count_enable_bit_nxt) begin
                    state_nxt = reload_timer_pkg::ST_IDLE;
                end else if (start_evt) begin
                    state_nxt = reload_timer_pkg::ST_RUN;
                end
            end
            reload_timer_pkg::ST_RUN: begin
                if (!count_enable_bit_nxt) begin
                    state_nxt = reload_timer_pkg::ST_IDLE;
                end else if (uf_evt && !reload_select_r) begin
                    state_nxt = reload_timer_pkg::ST_WAIT;
                end
            end
            default: begin
                state_nxt = reload_timer_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= reload_timer_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // down-counter
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_r <= `RT_CNT_RST;
        end else if (start_evt || (uf_evt && reload_select_r)) begin
            count_r <= reload_r;
        end else if (uf_evt) begin
            count_r <= `RT_CNT_WRAP;
        end else if (dec_evt) begin
            count_r <= count_r - `RT_CNT_STEP;
        end
    end

    // reload register, upper byte waits for lower byte
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reload_hi_buf_r <= `RT_BYTE_RST;
            reload_r        <= `RT_CNT_RST;
        end else begin
            if (wr_hi) begin
                reload_hi_buf_r <= wdata_in;
            end
            if (wr_lo) begin
                reload_r <= {reload_hi_buf_r, wdata_in};
            end
        end
    end

    // mode register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_clock_select_r  <= `RT_CSL_RST;
            trigger_mode_select_r <= `RT_MOD_RST;
        end else if (wr_mode) begin
            count_clock_select_r  <= wdata_in[`RT_F_CSL_HI:`RT_F_CSL_LO];
            trigger_mode_select_r <= wdata_in[`RT_F_MOD_HI:`RT_F_MOD_LO];
        end
    end

    // control register plain fields
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            output_pin_enable_r    <= 1'b0;
            output_level_select_r  <= 1'b0;
            reload_select_r        <= 1'b0;
            underflow_irq_enable_r <= 1'b0;
            count_enable_bit_r     <= 1'b0;
        end else if (wr_ctl) begin
            output_pin_enable_r    <= wdata_in[`RT_F_OUTPUT_PIN_ENABLE];
            output_level_select_r  <= wdata_in[`RT_F_OUTPUT_LEVEL_SELECT];
            reload_select_r        <= wdata_in[`RT_F_RELOAD_SELECT];
            underflow_irq_enable_r <= wdata_in[`RT_F_UNDERFLOW_IRQ_ENABLE];
            count_enable_bit_r     <= wdata_in[`RT_F_COUNT_ENABLE_BIT];
        end
    end

    // underflow flag, set wins over a clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            underflow_flag_r <= 1'b0;
        end else if (uf_evt) begin
            underflow_flag_r <= 1'b1;
        end else if (wr_ctl && !wdata_in[`RT_F_UF]) begin
            underflow_flag_r <= 1'b0;
        end
    end

    // start bit reads 1 until the first count tick
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            software_start_bit_r <= 1'b0;
        end else if (!count_enable_bit_nxt) begin
            software_start_bit_r <= 1'b0;
        end else if (sw_start) begin
            software_start_bit_r <= 1'b1;
        end else if (count_ok) begin
            software_start_bit_r <= 1'b0;
        end
    end

    // output toggle, cleared at start, inverted at underflow
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            toggle_r <= 1'b0;
        end else if (start_evt) begin
            toggle_r <= 1'b0;
        end else if (uf_evt) begin
            toggle_r <= !toggle_r;
        end
    end

    // timer output level
    assign timer_level_nxt = reload_select_r
                           ? (output_level_select_r ^ toggle_r)
                           : (output_level_select_r ^ running);

    // pin mux between timer and general-purpose port
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            timer_output_pin_out <= 1'b0;
        end else if (output_pin_enable_r) begin
            timer_output_pin_out <= timer_level_nxt;
        end else begin
            timer_output_pin_out <= gpio_out_in;
        end
    end

    // pin drive enable, low while driving
    assign timer_output_pin_oe_n_out = output_pin_enable_r ? 1'b0
                                     : !gpio_dir_in;

    // interrupt request
    assign underflow_irq_out = underflow_flag_r && underflow_irq_enable_r;

    // lower count byte frozen when the upper byte is read
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_lo_latch_r <= `RT_BYTE_RST;
        end else if (rd_in && addr_in == `RT_ADDR_HI) begin
            count_lo_latch_r <= count_r[7:0];
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clk_in) begin
        if (rst_in || !rd_in) begin
            rdata_r <= `RT_BYTE_RST;
        end else begin
            case (addr_in)
                `RT_ADDR_MODE: rdata_r <= {2'b00, count_clock_select_r,
                                           trigger_mode_select_r};
                `RT_ADDR_CTL:  rdata_r <= {1'b0, output_pin_enable_r,
                                           output_level_select_r,
                                           reload_select_r,
                                           underflow_irq_enable_r,
                                           underflow_flag_r,
                                           count_enable_bit_r,
                                           software_start_bit_r};
                `RT_ADDR_HI:   rdata_r <= count_r[15:8];
                `RT_ADDR_LO:   rdata_r <= count_lo_latch_r;
                default:       rdata_r <= `RT_BYTE_RST;
            endcase
        end
    end

    assign rdata_out = rdata_r;

    // checks on counter, flag and pin behaviour
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_uf_sets_flag: assert property (
        uf_evt |=> underflow_flag_r)
        else $error("underflow did not set flag");

    a_uf_irq_follows: assert property (
        uf_evt && underflow_irq_enable_r && !wr_ctl |=> underflow_irq_out)
        else $error("underflow irq missing");

    a_flag_holds: assert property (
        underflow_flag_r && !(wr_ctl && !wdata_in[`RT_F_UF]) |=> underflow_flag_r)
        else $error("flag cleared without write 0");

    a_reload_on_uf: assert property (
        uf_evt && reload_select_r |=> count_r == $past(reload_r) && running)
        else $error("reload at underflow failed");

    a_oneshot_stops: assert property (
        uf_evt && !reload_select_r && count_enable_bit_nxt
        |=> state_r == reload_timer_pkg::ST_WAIT && count_r == `RT_CNT_WRAP)
        else $error("one-shot did not halt");

    a_dec_by_one: assert property (
        dec_evt |=> count_r == $past(count_r) - `RT_CNT_STEP)
        else $error("count step wrong");

    a_hold_disabled: assert property (
        state_r == reload_timer_pkg::ST_IDLE && !start_evt |=> $stable(count_r))
        else $error("count moved while disabled");

    a_start_loads: assert property (
        start_evt |=> count_r == $past(reload_r) && running)
        else $error("start did not load reload value");

    a_gate_pause: assert property (
        running && gate_mode && !gate_on && !start_evt && count_enable_bit_nxt
        |=> $stable(count_r))
        else $error("gate did not pause count");

    a_toggle_on_uf: assert property (
        uf_evt |=> toggle_r != $past(toggle_r))
        else $error("output did not invert");

    a_pin_driven: assert property (
        output_pin_enable_r |=> timer_output_pin_out == $past(timer_level_nxt))
        else $error("pin not driven by timer");

    a_trg_clears: assert property (
        software_start_bit_r && count_ok |=> !software_start_bit_r)
        else $error("start bit stuck after counting");

    // main scenarios
    c_reload_uf:  cover property (uf_evt && reload_select_r);
    c_oneshot_uf: cover property (uf_evt && !reload_select_r);
    c_gate_pause: cover property (running && gate_mode && !gate_on);
    c_event_tick: cover property (event_mode && dec_evt);

endmodule

// ### hdl/reload_timer_consts.svh
// register map, field positions and reset values of the reload timer
`ifndef RELOAD_TIMER_CONSTS_SVH
`define RELOAD_TIMER_CONSTS_SVH

// register offsets
`define RT_ADDR_MODE   12'h040
`define RT_ADDR_CTL    12'h041
`define RT_ADDR_HI     12'hFA8
`define RT_ADDR_LO     12'hFA9

// mode register fields
`define RT_F_CSL_HI    5
`define RT_F_CSL_LO    3
`define RT_F_MOD_HI    2
`define RT_F_MOD_LO    0

// control register fields
`define RT_F_OUTPUT_PIN_ENABLE      6
`define RT_F_OUTPUT_LEVEL_SELECT      5
`define RT_F_RELOAD_SELECT      4
`define RT_F_UNDERFLOW_IRQ_ENABLE      3
`define RT_F_UF        2
`define RT_F_COUNT_ENABLE_BIT      1
`define RT_F_TRG       0

// trigger mode field bits
`define RT_M_GATE      2
`define RT_M_FALL      1
`define RT_M_RISE      0

// codes and values
`define RT_CSL_EVENT   3'h7
`define RT_CSL_RST     3'h0
`define RT_MOD_RST     3'h0
`define RT_CNT_RST     16'h0000
`define RT_CNT_ZERO    16'h0000
`define RT_CNT_WRAP    16'hFFFF
`define RT_CNT_STEP    16'h0001
`define RT_BYTE_RST    8'h00
`define RT_PRE_RST     7'h00
`define RT_PRE_STEP    7'h01
`define RT_PRE_TAPS    7

`endif

// ### hdl/reload_timer_pkg.sv
// types shared by the reload timer
package reload_timer_pkg;

    // operation state of the down-counter
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } run_state_e;

endpackage

// ### dv/pulse_source.sv
// model of the external pulse or gate source on the timer input pin
`timescale 1ns/1ps
module pulse_source #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // commands from the bench
    input  wire logic gate_on_in,
    input  wire logic gate_level_in,
    input  wire logic pulse_in,
    // timer input pin
    output logic      pin_out
);
    int left_r;

    // pin level: steady gate level, or one pulse WIDTH cycles long
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            left_r  <= 0;
            pin_out <= 1'b0;
        end else if (gate_on_in) begin
            left_r  <= 0;
            pin_out <= gate_level_in;
        end else if (pulse_in) begin
            left_r  <= WIDTH - 1;
            pin_out <= 1'b1;
        end else if (left_r > 0) begin
            left_r <= left_r - 1;
        end else begin
            pin_out <= 1'b0;  // low between pulses, no stale level
        end
    end
endmodule

// ### dv/test_reload_down_counter_timer.sv
// self-checking bench for the reload down-counter timer
`timescale 1ns/1ps
`include "reload_timer_consts.svh"
module test_reload_down_counter_timer;
    logic        clk_in;
    logic        rst_in;
    logic [11:0] addr_in;
    logic [7:0]  wdata_in;
    logic        wr_in;
    logic        rd_in;
    logic [7:0]  rdata_out;
    logic        pin_w;
    logic        gpio_out_in;
    logic        gpio_dir_in;
    logic        timer_output_pin_out;
    logic        timer_output_pin_oe_n_out;
    logic        underflow_irq_out;
    logic        gate_on;
    logic        gate_level;
    logic        pulse_req;
    int          errors;
    int          total_checks;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] c3;

    // device under test and pin source
    reload_down_counter_timer reload_down_counter_timer_i (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .timer_input_pin_in(pin_w), .gpio_out_in(gpio_out_in),
        .gpio_dir_in(gpio_dir_in), .timer_output_pin_out(timer_output_pin_out),
        .timer_output_pin_oe_n_out(timer_output_pin_oe_n_out),
        .underflow_irq_out(underflow_irq_out));
    pulse_source pulse_source_i (
        .clk_in(clk_in), .rst_in(rst_in), .gate_on_in(gate_on),
        .gate_level_in(gate_level), .pulse_in(pulse_req), .pin_out(pin_w));

    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    function automatic logic [15:0] b16(input logic v);
        return {15'h0000, v};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        d = rdata_out;
    endtask
    task automatic check_rd(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check({8'h00, d}, {8'h00, exp});
    endtask
    // upper byte first, it freezes the lower one
    task automatic rd16(output logic [15:0] v);
        logic [7:0] hi;
        logic [7:0] lo;
        rd(`RT_ADDR_HI, hi);
        rd(`RT_ADDR_LO, lo);
        v = {hi, lo};
    endtask
    task automatic set_reload(input logic [15:0] v);
        wr(`RT_ADDR_HI, v[15:8]);
        wr(`RT_ADDR_LO, v[7:0]);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_in);
            pulse_req <= 1'b1;
            @(posedge clk_in);
            pulse_req <= 1'b0;
            repeat (6) @(posedge clk_in);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        $display("[ERR] %0t: watchdog expired", $time);
        test_done();
    end

    // main sequence
    initial begin
        {rst_in, addr_in, wdata_in, wr_in, rd_in} = '0;
        {gpio_out_in, gpio_dir_in, gate_on, gate_level, pulse_req} = '0;
        errors = 0;
        total_checks = 0;
        rst_in = 1'b1;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        // reset values, reserved bits, unmapped address
        check_rd(`RT_ADDR_MODE, 8'h00);
        check_rd(`RT_ADDR_CTL, 8'h00);
        rd16(c1);
        check(c1, 16'h0000);
        check_rd(12'h123, 8'h00);
        check(b16(underflow_irq_out), 16'h0000);
        check(b16(timer_output_pin_oe_n_out), 16'h0001);
        wr(`RT_ADDR_MODE, 8'hFF);
        check_rd(`RT_ADDR_MODE, 8'h3F);
        wr(`RT_ADDR_CTL, 8'hF4);
        check_rd(`RT_ADDR_CTL, 8'h70);
        wr(`RT_ADDR_CTL, 8'h00);
        $display("test registers done");
        // software start: bit reads 1 until first count edge
        wr(`RT_ADDR_MODE, 8'h39);
        set_reload(16'h0003);
        wr(`RT_ADDR_CTL, 8'h13);
        repeat (5) @(posedge clk_in);
        check_rd(`RT_ADDR_CTL, 8'h13);
        pulses(1);
        check_rd(`RT_ADDR_CTL, 8'h12);
        wr(`RT_ADDR_MODE, 8'h00);
        wr(`RT_ADDR_CTL, 8'h13);
        repeat (30) @(posedge clk_in);
        check_rd(`RT_ADDR_CTL, 8'h16);
        wr(`RT_ADDR_CTL, 8'h10);
        rd16(c1);
        repeat (10) @(posedge clk_in);
        rd16(c2);
        check(c2, c1);
        check(b16(c1 <= 16'h0003), 16'h0001);
        check_rd(`RT_ADDR_CTL, 8'h10);
        $display("test software start done");
        // event count on rising, falling and both edges
        for (int m = 1; m <= 3; m++) begin
            wr(`RT_ADDR_CTL, 8'h00);
            wr(`RT_ADDR_MODE, 8'h38 | m[7:0]);
            set_reload(16'h0010);
            wr(`RT_ADDR_CTL, 8'h13);
            pulses(5);
            rd16(c1);
            check(c1, (m == 3) ? 16'h0006 : 16'h000B);
        end
        wr(`RT_ADDR_CTL, 8'h10);
        pulses(3);
        rd16(c2);
        check(c2, c1);
        $display("test event count done");
        // one-shot: output high while running, halt at underflow
        wr(`RT_ADDR_MODE, 8'h39);
        set_reload(16'h0002);
        wr(`RT_ADDR_CTL, 8'h4B);
        repeat (3) @(posedge clk_in);
        check(b16(timer_output_pin_out), 16'h0001);
        check(b16(timer_output_pin_oe_n_out), 16'h0000);
        pulses(3);
        check(b16(timer_output_pin_out), 16'h0000);
        check(b16(underflow_irq_out), 16'h0001);
        check_rd(`RT_ADDR_CTL, 8'h4E);
        pulses(1);
        rd16(c1);
        check(c1, 16'hFFFF);
        wr(`RT_ADDR_CTL, 8'h4A);
        #1;
        check(b16(underflow_irq_out), 16'h0000);
        $display("test one-shot done");
        // reload mode: toggle per underflow, both output levels
        for (int o = 0; o < 2; o++) begin
            wr(`RT_ADDR_CTL, 8'h00);
            set_reload(16'h0001);
            wr(`RT_ADDR_CTL, 8'h5B | {o[2:0], 5'h00});
            repeat (3) @(posedge clk_in);
            check(b16(timer_output_pin_out), b16(o[0]));
            pulses(2);
            check(b16(timer_output_pin_out), b16(~o[0]));
            check(b16(underflow_irq_out), 16'h0001);
            wr(`RT_ADDR_CTL, 8'h5A | {o[2:0], 5'h00});
            #1;
            check(b16(underflow_irq_out), 16'h0000);
            pulses(2);
            check(b16(timer_output_pin_out), b16(o[0]));
            check(b16(underflow_irq_out), 16'h0001);
            rd16(c1);
            check(c1, 16'h0001);
        end
        $display("test reload done");
        // external trigger on rising edge, internal clock
        wr(`RT_ADDR_CTL, 8'h00);
        wr(`RT_ADDR_MODE, 8'h01);
        set_reload(16'h0100);
        wr(`RT_ADDR_CTL, 8'h12);
        repeat (10) @(posedge clk_in);
        rd16(c1);
        check(c1, 16'h0001);
        pulses(1);
        rd16(c2);
        check(b16(c2 >= 16'h00F0 && c2 < 16'h0100), 16'h0001);
        $display("test external trigger done");
        // gate mode, active high: count, pause, resume
        wr(`RT_ADDR_CTL, 8'h00);
        wr(`RT_ADDR_MODE, 8'h05);
        wr(`RT_ADDR_CTL, 8'h12);
        @(posedge clk_in);
        gate_on    <= 1'b1;
        gate_level <= 1'b1;
        repeat (20) @(posedge clk_in);
        gate_level <= 1'b0;
        rd16(c1);
        repeat (20) @(posedge clk_in);
        rd16(c2);
        check(c2, c1);
        check(b16(c1 >= 16'h00E0 && c1 < 16'h0100), 16'h0001);
        gate_level <= 1'b1;
        repeat (20) @(posedge clk_in);
        gate_level <= 1'b0;
        rd16(c3);
        check(b16(c3 < c1 - 16'h0007 && c3 > c1 - 16'h000D), 16'h0001);
        // gate active low on a slower prescaler tap, one tick per 8 cycles
        wr(`RT_ADDR_CTL, 8'h00);
        wr(`RT_ADDR_MODE, 8'h14);
        set_reload(16'h0040);
        wr(`RT_ADDR_CTL, 8'h12);
        repeat (64) @(posedge clk_in);
        gate_level <= 1'b1;
        rd16(c1);
        repeat (16) @(posedge clk_in);
        rd16(c2);
        check(c2, c1);
        check(b16(c1 >= 16'h0037 && c1 <= 16'h0039), 16'h0001);
        gate_on <= 1'b0;
        $display("test gate done");
        // output enable off: port drives the pin
        wr(`RT_ADDR_CTL, 8'h00);
        gpio_dir_in <= 1'b1;
        gpio_out_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check(b16(timer_output_pin_out), 16'h0001);
        check(b16(timer_output_pin_oe_n_out), 16'h0000);
        gpio_dir_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check(b16(timer_output_pin_oe_n_out), 16'h0001);
        $display("test port pin done");
        test_done();
    end
endmodule
